// ### common/dcolf_consts.vh
// Overview of operation
// - fast clock: DC refresh 160 ms, settle 300 ms
// - slow clock: DC refresh 640 ms, settle 1200 ms
// - voltage DC held as 32-bit two's complement
// - current DC follows selected input A or B
// - measure DC follows measured signal, 32-bit
// - current measurement copies measure DC to backup
// - temperature measurement copies measure DC to backup
// - instant frequency refresh 20 ms or 80 ms
// - per-second frequency refresh 1.28 s or 5.12 s
// - average frequency refresh 10.24 s or 40.96 s
// - frequency registers read-only, DC registers writable
// - any reset returns data registers to defaults
`ifndef DCOLF_CONSTS_VH
`define DCOLF_CONSTS_VH

`define DCOLF_SYS_CLK_KHZ 40000
`define DCOLF_MS_TO_CYC(ms) ((ms) * `DCOLF_SYS_CLK_KHZ)

`define DCOLF_DC_UPD_FAST_MS 160
`define DCOLF_DC_UPD_SLOW_MS 640
`define DCOLF_DC_SET_FAST_MS 300
`define DCOLF_DC_SET_SLOW_MS 1200
`define DCOLF_FI_FAST_MS 20
`define DCOLF_FI_SLOW_MS 80
`define DCOLF_FS_FAST_MS 1280
`define DCOLF_FS_SLOW_MS 5120
`define DCOLF_FA_FAST_MS 10240
`define DCOLF_FA_SLOW_MS 40960

`define DCOLF_IDX_DC_CUR_BACKUP 10'h0F9
`define DCOLF_IDX_DC_TEMP_BACKUP 10'h101
`define DCOLF_IDX_DC_VOLTAGE 10'h114
`define DCOLF_IDX_DC_CURRENT 10'h115
`define DCOLF_IDX_DC_MEASURE 10'h116
`define DCOLF_IDX_HZ_PER_SECOND 10'h11D
`define DCOLF_IDX_HZ_AVERAGE 10'h11E
`define DCOLF_IDX_HZ_INSTANT 10'h19A
`define DCOLF_IDX_CTRL_STATUS 10'h1F0

`define DCOLF_CTRL_SLOW_BIT 0
`define DCOLF_CTRL_SWRST_BIT 1
`define DCOLF_STAT_SETTLED_BIT 8
`define DCOLF_STAT_MSRC_LSB 9

`define DCOLF_MSRC_OTHER 2'h0
`define DCOLF_MSRC_CUR_A 2'h1
`define DCOLF_MSRC_CUR_B 2'h2
`define DCOLF_MSRC_TEMP 2'h3

`define DCOLF_DATA_RESET 32'h00000000

`endif

// ### verilog/dcolf_tick_gen.v
module dcolf_tick_gen #(
    parameter [31:0] FAST_PERIOD = 32'h00000010,
    parameter [31:0] SLOW_PERIOD = 32'h00000040
) (
    input wire sys_clk,
    input wire rst,
    input wire restart,
    input wire slow,
    output reg tick_q
);
    reg [31:0] cnt_q;
    wire [31:0] last_w;

    assign last_w = (slow ? SLOW_PERIOD : FAST_PERIOD) - 32'h00000001;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (restart) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
        end else if (cnt_q >= last_w) begin
            cnt_q <= 32'h00000000;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h00000001;
            tick_q <= 1'b0;
        end
    end
endmodule // dcolf_tick_gen

// ### verilog/dcolf_results.v
// Implementation choice: the strobed register port.
`include "dcolf_consts.vh"

module dcolf_results #(
    parameter ADDR_W = 12,
    parameter [31:0] DC_UPD_FAST = `DCOLF_MS_TO_CYC(`DCOLF_DC_UPD_FAST_MS),
    parameter [31:0] DC_UPD_SLOW = `DCOLF_MS_TO_CYC(`DCOLF_DC_UPD_SLOW_MS),
    parameter [31:0] DC_SET_FAST = `DCOLF_MS_TO_CYC(`DCOLF_DC_SET_FAST_MS),
    parameter [31:0] DC_SET_SLOW = `DCOLF_MS_TO_CYC(`DCOLF_DC_SET_SLOW_MS),
    parameter [31:0] FI_FAST = `DCOLF_MS_TO_CYC(`DCOLF_FI_FAST_MS),
    parameter [31:0] FI_SLOW = `DCOLF_MS_TO_CYC(`DCOLF_FI_SLOW_MS),
    parameter [31:0] FS_FAST = `DCOLF_MS_TO_CYC(`DCOLF_FS_FAST_MS),
    parameter [31:0] FS_SLOW = `DCOLF_MS_TO_CYC(`DCOLF_FS_SLOW_MS),
    parameter [31:0] FA_FAST = `DCOLF_MS_TO_CYC(`DCOLF_FA_FAST_MS),
    parameter [31:0] FA_SLOW = `DCOLF_MS_TO_CYC(`DCOLF_FA_SLOW_MS)
) (
    input wire sys_clk,
    input wire rst,
    input wire rx_line_reset,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_q,
    input wire [31:0] dc_voltage_in,
    input wire [31:0] dc_current_a_in,
    input wire [31:0] dc_current_b_in,
    input wire current_input_b_sel,
    input wire [31:0] dc_measure_in,
    input wire [1:0] meas_src,
    input wire [31:0] hz_instant_in,
    input wire [31:0] hz_per_second_in,
    input wire [31:0] hz_average_in,
    output reg dc_update_q,
    output reg dc_settled_q
);
    // register word index from a byte address; misaligned never hits
    function hit;
        input [ADDR_W-1:0] addr;
        input [9:0] idx;
        begin
            hit = (addr[1:0] == 2'h0) && (addr[ADDR_W-1:2] == idx);
        end
    endfunction

    reg [31:0] dc_voltage_result_q;
    reg [31:0] dc_current_result_q;
    reg [31:0] dc_measure_channel_result_q;
    reg [31:0] dc_current_meas_backup_q;
    reg [31:0] dc_temperature_backup_q;
    reg [31:0] line_hz_instant_q;
    reg [31:0] line_hz_per_second_q;
    reg [31:0] line_hz_average_q;
    reg slow_q;
    reg sw_reset_q;
    reg [31:0] settle_cnt_q;
    reg [31:0] rdata_d;

    wire dc_tick;
    wire hz_inst_tick;
    wire hz_sec_tick;
    wire hz_avg_tick;
    wire ctrl_wr;
    wire slow_d;
    wire rate_change;
    wire data_clear;
    wire timer_restart;
    wire [31:0] settle_last;
    wire [31:0] dc_current_sel;

    assign ctrl_wr = reg_wr && hit(reg_addr, `DCOLF_IDX_CTRL_STATUS);
    assign slow_d = ctrl_wr ? reg_wdata[`DCOLF_CTRL_SLOW_BIT] : slow_q;
    assign rate_change = ctrl_wr && (slow_d != slow_q);
    // rx reset and the software reset both wipe results
    assign data_clear = rx_line_reset | sw_reset_q;
    // a new metering rate restarts every interval and the settling wait
    assign timer_restart = data_clear | rate_change;
    assign settle_last = (slow_q ? DC_SET_SLOW : DC_SET_FAST) - 32'h00000001;
    assign dc_current_sel = current_input_b_sel ? dc_current_b_in : dc_current_a_in;

    dcolf_tick_gen #(
        .FAST_PERIOD(DC_UPD_FAST),
        .SLOW_PERIOD(DC_UPD_SLOW)
    ) u_dc_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(timer_restart),
        .slow(slow_q),
        .tick_q(dc_tick)
    );

    dcolf_tick_gen #(
        .FAST_PERIOD(FI_FAST),
        .SLOW_PERIOD(FI_SLOW)
    ) u_hz_inst_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(timer_restart),
        .slow(slow_q),
        .tick_q(hz_inst_tick)
    );

    dcolf_tick_gen #(
        .FAST_PERIOD(FS_FAST),
        .SLOW_PERIOD(FS_SLOW)
    ) u_hz_sec_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(timer_restart),
        .slow(slow_q),
        .tick_q(hz_sec_tick)
    );

    dcolf_tick_gen #(
        .FAST_PERIOD(FA_FAST),
        .SLOW_PERIOD(FA_SLOW)
    ) u_hz_avg_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .restart(timer_restart),
        .slow(slow_q),
        .tick_q(hz_avg_tick)
    );

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            slow_q <= 1'b0;
            sw_reset_q <= 1'b0;
        end else begin
            slow_q <= slow_d;
            sw_reset_q <= ctrl_wr & reg_wdata[`DCOLF_CTRL_SWRST_BIT];
        end
    end

    // settling wait; restarts with the update timers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settle_cnt_q <= 32'h00000000;
            dc_settled_q <= 1'b0;
        end else if (timer_restart) begin
            settle_cnt_q <= 32'h00000000;
            dc_settled_q <= 1'b0;
        end else if (!dc_settled_q) begin
            if (settle_cnt_q >= settle_last) begin
                dc_settled_q <= 1'b1;
            end else begin
                settle_cnt_q <= settle_cnt_q + 32'h00000001;
            end
        end
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dc_update_q <= 1'b0;
        end else begin
            dc_update_q <= dc_tick;
        end
    end

    // DC results: the periodic refresh beats a host write in the same cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dc_voltage_result_q <= `DCOLF_DATA_RESET;
            dc_current_result_q <= `DCOLF_DATA_RESET;
            dc_measure_channel_result_q <= `DCOLF_DATA_RESET;
        end else if (data_clear) begin
            dc_voltage_result_q <= `DCOLF_DATA_RESET;
            dc_current_result_q <= `DCOLF_DATA_RESET;
            dc_measure_channel_result_q <= `DCOLF_DATA_RESET;
        end else if (dc_tick) begin
            dc_voltage_result_q <= dc_voltage_in;
            dc_current_result_q <= dc_current_sel;
            dc_measure_channel_result_q <= dc_measure_in;
        end else if (reg_wr) begin
            if (hit(reg_addr, `DCOLF_IDX_DC_VOLTAGE)) begin
                dc_voltage_result_q <= reg_wdata;
            end
            if (hit(reg_addr, `DCOLF_IDX_DC_CURRENT)) begin
                dc_current_result_q <= reg_wdata;
            end
            if (hit(reg_addr, `DCOLF_IDX_DC_MEASURE)) begin
                dc_measure_channel_result_q <= reg_wdata;
            end
        end
    end

    // backups take the same fresh value as the measure register
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dc_current_meas_backup_q <= `DCOLF_DATA_RESET;
            dc_temperature_backup_q <= `DCOLF_DATA_RESET;
        end else if (data_clear) begin
            dc_current_meas_backup_q <= `DCOLF_DATA_RESET;
            dc_temperature_backup_q <= `DCOLF_DATA_RESET;
        end else begin
            if (dc_tick && (meas_src == `DCOLF_MSRC_CUR_A || meas_src == `DCOLF_MSRC_CUR_B)) begin
                dc_current_meas_backup_q <= dc_measure_in;
            end else if (reg_wr && hit(reg_addr, `DCOLF_IDX_DC_CUR_BACKUP)) begin
                dc_current_meas_backup_q <= reg_wdata;
            end
            if (dc_tick && meas_src == `DCOLF_MSRC_TEMP) begin
                dc_temperature_backup_q <= dc_measure_in;
            end else if (reg_wr && hit(reg_addr, `DCOLF_IDX_DC_TEMP_BACKUP)) begin
                dc_temperature_backup_q <= reg_wdata;
            end
        end
    end

    // frequency results: no write path exists at all
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            line_hz_instant_q <= `DCOLF_DATA_RESET;
            line_hz_per_second_q <= `DCOLF_DATA_RESET;
            line_hz_average_q <= `DCOLF_DATA_RESET;
        end else if (data_clear) begin
            line_hz_instant_q <= `DCOLF_DATA_RESET;
            line_hz_per_second_q <= `DCOLF_DATA_RESET;
            line_hz_average_q <= `DCOLF_DATA_RESET;
        end else begin
            if (hz_inst_tick) begin
                line_hz_instant_q <= hz_instant_in;
            end
            if (hz_sec_tick) begin
                line_hz_per_second_q <= hz_per_second_in;
            end
            if (hz_avg_tick) begin
                line_hz_average_q <= hz_average_in;
            end
        end
    end

    always @* begin
        rdata_d = 32'h00000000;
        if (reg_rd) begin
            if (hit(reg_addr, `DCOLF_IDX_DC_CUR_BACKUP)) begin
                rdata_d = dc_current_meas_backup_q;
            end else if (hit(reg_addr, `DCOLF_IDX_DC_TEMP_BACKUP)) begin
                rdata_d = dc_temperature_backup_q;
            end else if (hit(reg_addr, `DCOLF_IDX_DC_VOLTAGE)) begin
                rdata_d = dc_voltage_result_q;
            end else if (hit(reg_addr, `DCOLF_IDX_DC_CURRENT)) begin
                rdata_d = dc_current_result_q;
            end else if (hit(reg_addr, `DCOLF_IDX_DC_MEASURE)) begin
                rdata_d = dc_measure_channel_result_q;
            end else if (hit(reg_addr, `DCOLF_IDX_HZ_PER_SECOND)) begin
                rdata_d = line_hz_per_second_q;
            end else if (hit(reg_addr, `DCOLF_IDX_HZ_AVERAGE)) begin
                rdata_d = line_hz_average_q;
            end else if (hit(reg_addr, `DCOLF_IDX_HZ_INSTANT)) begin
                rdata_d = line_hz_instant_q;
            end else if (hit(reg_addr, `DCOLF_IDX_CTRL_STATUS)) begin
                rdata_d[`DCOLF_CTRL_SLOW_BIT] = slow_q;
                rdata_d[`DCOLF_STAT_SETTLED_BIT] = dc_settled_q;
                rdata_d[`DCOLF_STAT_MSRC_LSB+1:`DCOLF_STAT_MSRC_LSB] = meas_src;
            end
        end
    end

    // read data stands one cycle only, zero otherwise
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q <= 32'h00000000;
        end else begin
            reg_rdata_q <= rdata_d;
        end
    end
endmodule // dcolf_results

// ### dv/dcolf_results_props.sv
`include "dcolf_consts.vh"
module dcolf_results_props (
    input wire sys_clk,
    input wire rst,
    input wire rx_line_reset,
    input wire [11:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_q,
    input wire [1:0] meas_src,
    input wire dc_update_q,
    input wire dc_settled_q
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] gap_q;
    logic [7:0] since_q;
    // ctrl writes that change the rate or set the software reset restart every timer, so gaps are measured from every ctrl write
    wire restart = rx_line_reset | (reg_wr & (reg_addr == 12'h7C0));
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gap_q <= 8'h00;
            since_q <= 8'h00;
        end else begin
            gap_q <= (restart | dc_update_q) ? 8'h00 : gap_q + 8'h01;
            since_q <= restart ? 8'h00 : since_q + 8'h01;
        end
    end
    sequence wr_volt;
        reg_wr && !rx_line_reset && reg_addr == 12'h450;
    endsequence
    sequence rd_volt;
        reg_rd && reg_addr == 12'h450;
    endsequence
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h00000000)
        else $error("read data outside read slot");
    a_update_gap_bound: assert property (gap_q <= 8'h46)
        else $error("dc refresh overdue");
    a_update_single_pulse: assert property (dc_update_q |=> (!dc_update_q) [*8])
        else $error("dc refresh too soon");
    a_settle_clear_rx: assert property (rx_line_reset |=> !dc_settled_q)
        else $error("settled kept over line reset");
    a_settle_not_early: assert property ($rose(dc_settled_q) |-> since_q >= 8'h1C)
        else $error("settled too early");
    a_quiet_after_rx: assert property ($fell(rx_line_reset) |=> (!dc_update_q) [*8])
        else $error("timers not restarted");
    a_status_src_read: assert property (reg_rd && reg_addr == 12'h7C0 |=>
        reg_rdata_q[10:9] == $past(meas_src) && !reg_rdata_q[1])
        else $error("status read wrong");
    // a refresh in the write cycle shows as a pulse in the read cycle and wins
    a_dc_write_read: assert property (wr_volt ##1 (rd_volt && !dc_update_q) |=>
        reg_rdata_q == $past(reg_wdata, 2))
        else $error("written dc value lost");
endmodule // dcolf_results_props
bind dcolf_results dcolf_results_props u_props (
    .sys_clk(sys_clk), .rst(rst), .rx_line_reset(rx_line_reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .meas_src(meas_src), .dc_update_q(dc_update_q), .dc_settled_q(dc_settled_q));

// ### dv/dcolf_host.sv
module dcolf_host (
    input wire sys_clk,
    input wire [31:0] reg_rdata_q,
    output logic [11:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        reg_addr = 12'h000;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // step off the edge after release so a following access never reassigns in one step
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        reg_addr <= {idx, 2'b00};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [9:0] idx, output logic [31:0] d);
        reg_addr <= {idx, 2'b00};
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask
endmodule // dcolf_host

// ### dv/dcolf_testbench.sv
`include "dcolf_consts.vh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst, rx_line_reset, current_input_b_sel, reg_wr, reg_rd, dc_update_q;
    logic dc_settled_q;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_q, dc_voltage_in, dc_current_a_in, dc_current_b_in;
    logic [31:0] dc_measure_in, hz_instant_in, hz_per_second_in, hz_average_in, rv;
    logic [1:0] meas_src;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    dcolf_results #(.DC_UPD_FAST(16), .DC_UPD_SLOW(64), .DC_SET_FAST(30), .DC_SET_SLOW(120),
        .FI_FAST(4), .FI_SLOW(8), .FS_FAST(32), .FS_SLOW(128), .FA_FAST(64), .FA_SLOW(256)) DUT (
        .sys_clk(sys_clk), .rst(rst), .rx_line_reset(rx_line_reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .dc_voltage_in(dc_voltage_in), .dc_current_a_in(dc_current_a_in),
        .dc_current_b_in(dc_current_b_in), .current_input_b_sel(current_input_b_sel),
        .dc_measure_in(dc_measure_in), .meas_src(meas_src), .hz_instant_in(hz_instant_in),
        .hz_per_second_in(hz_per_second_in), .hz_average_in(hz_average_in),
        .dc_update_q(dc_update_q), .dc_settled_q(dc_settled_q));
    dcolf_host host (.sys_clk(sys_clk), .reg_rdata_q(reg_rdata_q), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task final_report;
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task rdc(input logic [9:0] idx, input logic [31:0] exp);
        host.rd(idx, rv);
        check(rv, exp);
    endtask
    // returns at the edge where the refresh pulse is seen; n+1 is the spacing
    task wait_upd;
        n = 0;
        @(posedge sys_clk);
        while (dc_update_q !== 1'b1 && n < 300) begin
            n++;
            @(posedge sys_clk);
        end
    endtask
    task s_reset;
        rdc(`DCOLF_IDX_DC_VOLTAGE, 32'h00000000);
        rdc(`DCOLF_IDX_DC_CURRENT, 32'h00000000);
        rdc(`DCOLF_IDX_DC_MEASURE, 32'h00000000);
        rdc(`DCOLF_IDX_DC_CUR_BACKUP, 32'h00000000);
        rdc(`DCOLF_IDX_HZ_AVERAGE, 32'h00000000);
        rdc(10'h3FF, 32'h00000000);
    endtask
    task s_dc;
        wait_upd;
        rdc(`DCOLF_IDX_DC_VOLTAGE, 32'hFFFFF123);
        rdc(`DCOLF_IDX_DC_CURRENT, 32'h00000A11);
        rdc(`DCOLF_IDX_DC_MEASURE, 32'h00000C33);
        current_input_b_sel <= 1'b1;
        dc_current_b_in <= 32'h00000B44;
        meas_src <= `DCOLF_MSRC_CUR_A;
        wait_upd;
        rdc(`DCOLF_IDX_DC_CURRENT, 32'h00000B44);
        rdc(`DCOLF_IDX_DC_CUR_BACKUP, 32'h00000C33);
        rdc(`DCOLF_IDX_CTRL_STATUS, 32'h00000300);
        meas_src <= `DCOLF_MSRC_TEMP;
        dc_measure_in <= 32'hFFFFFC44;
        wait_upd;
        rdc(`DCOLF_IDX_DC_TEMP_BACKUP, 32'hFFFFFC44);
        rdc(`DCOLF_IDX_DC_CUR_BACKUP, 32'h00000C33);
        rdc(`DCOLF_IDX_DC_MEASURE, 32'hFFFFFC44);
    endtask
    task s_rate;
        wait_upd;
        wait_upd;
        check(32'(n + 1), 32'h00000010);
        host.wr(`DCOLF_IDX_CTRL_STATUS, 32'h00000001);
        wait_upd;
        wait_upd;
        check(32'(n + 1), 32'h00000040);
        host.wr(`DCOLF_IDX_CTRL_STATUS, 32'h00000000);
    endtask
    task s_line_hz_instant;
        hz_instant_in <= 32'h00001390;
        hz_per_second_in <= 32'h00001391;
        hz_average_in <= 32'h00001392;
        repeat (70) @(posedge sys_clk);
        rdc(`DCOLF_IDX_HZ_INSTANT, 32'h00001390);
        rdc(`DCOLF_IDX_HZ_PER_SECOND, 32'h00001391);
        rdc(`DCOLF_IDX_HZ_AVERAGE, 32'h00001392);
        host.wr(`DCOLF_IDX_HZ_INSTANT, 32'h00000055);
        host.wr(`DCOLF_IDX_HZ_PER_SECOND, 32'h00000066);
        host.wr(`DCOLF_IDX_HZ_AVERAGE, 32'h00000077);
        rdc(`DCOLF_IDX_HZ_INSTANT, 32'h00001390);
        rdc(`DCOLF_IDX_HZ_PER_SECOND, 32'h00001391);
        rdc(`DCOLF_IDX_HZ_AVERAGE, 32'h00001392);
    endtask
    task s_write;
        wait_upd;
        host.wr(`DCOLF_IDX_DC_VOLTAGE, 32'h0000ABCD);
        dc_voltage_in <= 32'h00000456;
        current_input_b_sel <= 1'b0;
        dc_current_a_in <= 32'h00000A55;
        rdc(`DCOLF_IDX_DC_VOLTAGE, 32'h0000ABCD);
        wait_upd;
        rdc(`DCOLF_IDX_DC_VOLTAGE, 32'h00000456);
        rdc(`DCOLF_IDX_DC_CURRENT, 32'h00000A55);
    endtask
    task s_rx;
        rx_line_reset <= 1'b1;
        @(posedge sys_clk);
        rx_line_reset <= 1'b0;
        @(posedge sys_clk);
        check({31'h00000000, dc_settled_q}, 32'h00000000);
        rdc(`DCOLF_IDX_DC_VOLTAGE, 32'h00000000);
        rdc(`DCOLF_IDX_HZ_INSTANT, 32'h00000000);
        wait_upd;
        host.wr(`DCOLF_IDX_CTRL_STATUS, 32'h00000002);
        @(posedge sys_clk);
        rdc(`DCOLF_IDX_DC_TEMP_BACKUP, 32'h00000000);
    endtask
    initial begin
        rst = 1'b1;
        rx_line_reset = 1'b0;
        current_input_b_sel = 1'b0;
        meas_src = `DCOLF_MSRC_OTHER;
        dc_voltage_in = 32'hFFFFF123;
        dc_current_a_in = 32'h00000A11;
        dc_current_b_in = 32'h00000B22;
        dc_measure_in = 32'h00000C33;
        hz_instant_in = 32'h00001388;
        hz_per_second_in = 32'h00001389;
        hz_average_in = 32'h0000138A;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        s_reset;
        s_dc;
        s_rate;
        s_line_hz_instant;
        s_write;
        s_rx;
        final_report;
    end
    initial begin
        #200000;
        fail_count++;
        final_report;
    end
endmodule // testbench
